// >>> verilog/cric_cpu_ctrl.sv
// Processor end: reset, interrupt, halt, lock and I/O address control
//
// How it works
// - I/O address on 15..0, top four zero
// - Outside holds reset over four clocks
// - Reset synchronised; aborts and holds idle
// - Seven-clock init, then fetch restart address
// - Outside releases reset 50 us after power
// - NMI ignored before second clock after reset
// - Vector table 256 entries, four bytes each
// - Type byte times four forms pointer
// - NMI rising edge, above maskable, type 2
// - Outside holds NMI high over two clocks
// - Latched NMI served at instruction boundary
// - Maskable sampled at instruction end or in halt, gated by enable
// - Requester holds maskable before instruction end
// - Requester may drop after first strobe
// - Interrupt pushes flags and clears enable
// - Two acknowledges, lock between in maximum mode, hold deferred
// - Halt entry shows status per strap mode
// - Hold keeps halt; reissue after; irq exits
// - Lock low after prefix, until instruction ends
// - Hold request recorded during lock, granted after
`timescale 1ns/100ps
`include "cric_map.svh"
module cric_cpu_ctrl
    import cric_pkg::*;
#(
    parameter int ACK_CYC  = 4, // Clocks per acknowledge bus cycle
    parameter int INIT_CYC = `CRIC_INIT_CYC
) (
    // Clock and reset
    input  wire logic  ref_clk_i,
    input  wire logic  nrst_i,
    // Link
    cric_if.cpu        link,
    // Core side
    input  wire logic        instr_end_i,   // Instruction or whole move boundary
    input  wire logic        halt_exec_i,   // HALT instruction executed
    input  wire logic        lock_prefix_i, // Lock prefix decoded
    input  wire logic        locked_end_i,  // Last bus cycle of locked instruction ends
    input  wire logic        io_req_i,      // I/O cycle request
    input  wire logic        io_write_i,    // I/O cycle is a write
    input  wire logic        io_direct_i,   // Direct form (8-bit port)
    input  wire logic [15:0] io_port_i,     // Port number or port_pointer_reg
    input  wire logic        flags_load_i,  // Flags restored
    input  wire logic        if_set_i,      // Software sets enable
    input  wire logic        if_value_i,    // Enable from restored flags
    output logic             fetch_o,       // Pulse: fetch at fetch_addr_o
    output logic [19:0]      fetch_addr_o,
    output logic             vector_o,      // Pulse: vector_ptr_o valid
    output logic [9:0]       vector_ptr_o,
    output logic             push_flags_o,  // Pulse: push prior flags
    output logic             int_en_o,      // Interrupt-enable flag
    output logic             halted_o,
    output logic             busy_o         // Reset or init running
);
    cric_state_t state_q;             // Main state
    cric_state_t resume_q;            // State to return to after hold
    logic [3:0]  cnt_q;               // Cycle counter
    logic        nmi_pend_q;          // Latched NMI edge
    logic [1:0]  nmi_blank_q;         // Clocks since reset release
    logic        int_en_q;            // Enable flag
    logic        lock_q;              // Lock prefix active
    logic        ack_lock_q;          // Lock across acknowledges
    logic        hold_pend_q;         // Recorded hold request
    logic        grant_q;             // Bus granted
    logic        halt_ind_q;          // One-clock halt indication pulse
    logic        as_q;                // Address strobe
    logic [2:0]  status_q;            // Cycle status
    logic [19:0] addr_q;
    logic        mio_q, dir_q, ssz_q, irq_ack_strobe_q;
    logic        fetch_q, vec_q, push_q;
    logic [19:0] fetch_addr_q;
    logic [9:0]  vec_ptr_q;
    logic        rst_lvl, rst_rise, rst_fall, nmi_rise, irq_lvl;
    logic        minimum;

    // Type byte to table pointer
    function automatic logic [9:0] vec_ptr(input logic [7:0] t);
        return {t, 2'b00};
    endfunction : vec_ptr

    // Reset, NMI and maskable link inputs pass two-flop synchronisers
    cric_edge_sync u_rst (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .sig_i(link.reset_in),
                          .level_o(rst_lvl), .rise_o(rst_rise));
    cric_edge_sync u_nmi (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .sig_i(link.nmi_in),
                          .level_o(), .rise_o(nmi_rise));
    cric_edge_sync u_irq (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .sig_i(link.mask_irq_in),
                          .level_o(irq_lvl), .rise_o());

    // Falling edge of synchronised reset marks the start of init
    logic rst_prev_q;
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) rst_prev_q <= 1'b0; // Matches the synchroniser, so no false fall
        else         rst_prev_q <= rst_lvl;
    end
    assign rst_fall = rst_prev_q & ~rst_lvl;
    assign minimum  = link.config_strap;

    // Main sequence
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q  <= CRIC_RESET;
            resume_q <= CRIC_RUN;
            cnt_q    <= 4'h0;
        end else if (rst_lvl || rst_rise) begin
            state_q <= CRIC_RESET;
            cnt_q   <= 4'h0;
        end else begin
            unique case (state_q)
                CRIC_RESET: if (rst_fall) state_q <= CRIC_INIT;
                CRIC_INIT: begin
                    // Fixed init length before the first fetch
                    if (cnt_q == 4'(INIT_CYC - 1)) begin
                        state_q <= CRIC_RUN;
                        cnt_q   <= 4'h0;
                    end else cnt_q <= cnt_q + 4'h1;
                end
                CRIC_RUN: begin
                    if (hold_pend_q && !lock_q) begin
                        resume_q <= CRIC_RUN;
                        state_q  <= CRIC_HOLD;
                    end else if (instr_end_i && nmi_pend_q) begin
                        state_q <= CRIC_RUN; // NMI skips acknowledge
                    end else if (instr_end_i && irq_lvl && int_en_q) begin
                        state_q <= CRIC_ACK1;
                        cnt_q   <= 4'h0;
                    end else if (halt_exec_i) state_q <= CRIC_HALT;
                end
                CRIC_ACK1, CRIC_ACK2: begin
                    // Back-to-back acknowledge cycles; no hold in between
                    if (cnt_q == 4'(ACK_CYC - 1)) begin
                        cnt_q   <= 4'h0;
                        state_q <= (state_q == CRIC_ACK1) ? CRIC_ACK2 : CRIC_RUN;
                    end else cnt_q <= cnt_q + 4'h1;
                end
                CRIC_HALT: begin
                    if (nmi_pend_q) state_q <= CRIC_RUN;
                    else if (irq_lvl && int_en_q) state_q <= CRIC_ACK1;
                    else if (hold_pend_q) begin
                        resume_q <= CRIC_HALT;
                        state_q  <= CRIC_HOLD;
                    end
                end
                CRIC_HOLD: if (!link.hold_req) state_q <= resume_q;
                default: state_q <= CRIC_RESET;
            endcase
        end
    end

    // NMI latch, blank two clocks after reset; set wins
    logic nmi_take;
    assign nmi_take = (state_q == CRIC_RUN && instr_end_i && !(hold_pend_q && !lock_q))
                    || (state_q == CRIC_HALT);
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) {nmi_pend_q, nmi_blank_q} <= 3'h0;
        else if (rst_lvl) {nmi_pend_q, nmi_blank_q} <= 3'h0;
        else begin
            if (nmi_blank_q != 2'(`CRIC_NMI_BLANK_CYC)) nmi_blank_q <= nmi_blank_q + 2'h1;
            if (nmi_rise && nmi_blank_q == 2'(`CRIC_NMI_BLANK_CYC))
                nmi_pend_q <= 1'b1;
            else if (nmi_take && nmi_pend_q)
                nmi_pend_q <= 1'b0;
        end
    end

    // Interrupt-enable flag; cleared on every interrupt response
    logic int_taken;
    assign int_taken = nmi_take && (nmi_pend_q || (irq_lvl && int_en_q));
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i)            int_en_q <= 1'b0;
        else if (rst_lvl)       int_en_q <= 1'b0;
        else if (int_taken)     int_en_q <= 1'b0;
        else if (flags_load_i)  int_en_q <= if_value_i;
        else if (if_set_i)      int_en_q <= 1'b1;
    end

    // Lock, and hold recorded during it
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) {lock_q, ack_lock_q, hold_pend_q, grant_q} <= 4'h0;
        else if (rst_lvl) {lock_q, ack_lock_q, hold_pend_q, grant_q} <= 4'h0;
        else begin
            if (lock_prefix_i) lock_q <= 1'b1;
            else if (locked_end_i) lock_q <= 1'b0;
            // Acknowledge lock, maximum mode only
            if (!minimum && state_q == CRIC_ACK1 && cnt_q == 4'h0) ack_lock_q <= 1'b1;
            else if (state_q == CRIC_ACK2 && cnt_q == 4'h0) ack_lock_q <= 1'b0;
            if (link.hold_req && !hold_pend_q) hold_pend_q <= 1'b1;
            else if (state_q == CRIC_HOLD && !link.hold_req) hold_pend_q <= 1'b0;
            grant_q <= (state_q == CRIC_HOLD) && link.hold_req;
        end
    end

    // Halt indication, strobes, I/O address
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            status_q <= `CRIC_ST_PASSIVE;
            addr_q   <= 20'h00000;
            {mio_q, dir_q, ssz_q, irq_ack_strobe_q, halt_ind_q, as_q} <= 6'h00;
        end else begin
            // Halt indication on entry and again when a hold ends
            halt_ind_q <= (state_q == CRIC_RUN && halt_exec_i)
                        || (state_q == CRIC_HOLD && !link.hold_req && resume_q == CRIC_HALT);
            as_q     <= halt_ind_q && minimum; // delayed by one clock
            irq_ack_strobe_q   <= (state_q == CRIC_ACK1 || state_q == CRIC_ACK2)
                        && cnt_q >= 4'h1 && cnt_q <= 4'h2;
            status_q <= `CRIC_ST_PASSIVE;
            {mio_q, dir_q, ssz_q} <= 3'h0;
            if (state_q == CRIC_HALT && !minimum) status_q <= `CRIC_ST_HALT;
            else if (state_q == CRIC_HALT) {mio_q, dir_q, ssz_q} <= 3'b101;
            else if (state_q == CRIC_ACK1 || state_q == CRIC_ACK2) status_q <= `CRIC_ST_IRQ_ACK_STROBE;
            else if (state_q == CRIC_RUN && io_req_i) begin
                // Direct form reaches only page 0; top nibble always zero
                addr_q   <= {4'h0, io_direct_i ? {8'h00, io_port_i[7:0]} : io_port_i};
                status_q <= io_write_i ? `CRIC_ST_IOWR : `CRIC_ST_IORD;
                {mio_q, dir_q} <= {1'b1, io_write_i};
            end
        end
    end

    // Restart fetch, vector pointer, flag push
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            {fetch_q, vec_q, push_q} <= 3'h0;
            fetch_addr_q <= 20'h00000;
            vec_ptr_q    <= 10'h000;
        end else begin
            fetch_q <= state_q == CRIC_INIT && cnt_q == 4'(INIT_CYC - 1);
            if (state_q == CRIC_INIT) fetch_addr_q <= `CRIC_RESTART_ADDR;
            push_q <= int_taken;
            vec_q  <= 1'b0;
            if (int_taken && nmi_pend_q) begin
                vec_q     <= 1'b1;
                vec_ptr_q <= vec_ptr(`CRIC_NMI_TYPE);
            end else if (state_q == CRIC_ACK2 && cnt_q == 4'h2) begin
                vec_q     <= 1'b1;
                vec_ptr_q <= vec_ptr(link.type_byte);
            end
        end
    end

    assign link.irq_ack_strobe  = irq_ack_strobe_q;
    assign link.lock_n          = ~(lock_q | ack_lock_q);
    assign link.hold_grant      = grant_q;
    assign link.addr            = addr_q;
    assign link.addr_strobe     = as_q;
    assign link.cycle_status    = status_q;
    assign link.mem_io          = mio_q;
    assign link.xfer_direction  = dir_q;
    assign link.status_zero_out = ssz_q;
    assign fetch_o      = fetch_q;
    assign fetch_addr_o = fetch_addr_q;
    assign vector_o     = vec_q;
    assign vector_ptr_o = vec_ptr_q;
    assign push_flags_o = push_q;
    assign int_en_o     = int_en_q;
    assign halted_o     = state_q == CRIC_HALT;
    assign busy_o       = state_q == CRIC_RESET || state_q == CRIC_INIT;
endmodule : cric_cpu_ctrl

// >>> common/cric_map.svh
// Codes and timing counts of the reset/interrupt control
`ifndef CRIC_MAP_SVH
`define CRIC_MAP_SVH
`define CRIC_CLK_PERIOD_NS    25
`define CRIC_RST_HOLD_CYC     5
`define CRIC_INIT_CYC         7
`define CRIC_NMI_BLANK_CYC    2
`define CRIC_NMI_MIN_HIGH_CYC 3
`define CRIC_PWRUP_US         50
`define CRIC_PWRUP_CYC        ((`CRIC_PWRUP_US * 1000 + `CRIC_CLK_PERIOD_NS - 1) / `CRIC_CLK_PERIOD_NS)
`define CRIC_RESTART_ADDR     20'hFFFF0
`define CRIC_NMI_TYPE         8'h02
`define CRIC_VEC_SHIFT        2
`define CRIC_DIRECT_PORTS     256
`define CRIC_ST_IRQ_ACK_STROBE          3'h0
`define CRIC_ST_IORD          3'h1
`define CRIC_ST_IOWR          3'h2
`define CRIC_ST_HALT          3'h3
`define CRIC_ST_PASSIVE       3'h7
`define CRIC_IF_BIT           9
`endif

// >>> common/cric_pkg.sv
// Types used by the processor end of the reset/interrupt control link
package cric_pkg;
    typedef enum logic [2:0] {
        CRIC_RUN   = 3'h0,
        CRIC_ACK1  = 3'h1,
        CRIC_ACK2  = 3'h2,
        CRIC_HALT  = 3'h3,
        CRIC_HOLD  = 3'h4,
        CRIC_INIT  = 3'h5,
        CRIC_RESET = 3'h6
    } cric_state_t;
endpackage : cric_pkg

// >>> common/cric_if.sv
// Link between the processor control end and the outside system end
`timescale 1ns/100ps
interface cric_if;
    logic        reset_in;        // High holds the processor in reset
    logic        nmi_in;          // Non-maskable request, rising edge
    logic        mask_irq_in;     // Maskable request, level
    logic        irq_ack_strobe;  // High during an acknowledge strobe
    logic [7:0]  type_byte;       // Vector type from the outside
    logic        lock_n;          // Bus-lock, active low
    logic        hold_req;        // Request on req_grant_pin
    logic        hold_grant;      // Grant on req_grant_pin
    logic [19:0] addr;            // Address bus
    logic        addr_strobe;     // Address latch pulse
    logic [2:0]  cycle_status;    // cycle_status_2..0
    logic        mem_io;          // High for I/O in minimum mode
    logic        xfer_direction;  // High for write
    logic        status_zero_out; // Minimum-mode status bit zero
    logic        config_strap;    // High: minimum, low: maximum
    modport cpu (input reset_in, nmi_in, mask_irq_in, type_byte, hold_req, config_strap,
                 output irq_ack_strobe, lock_n, hold_grant, addr, addr_strobe,
                 cycle_status, mem_io, xfer_direction, status_zero_out);
    modport sys (output reset_in, nmi_in, mask_irq_in, type_byte, hold_req, config_strap,
                 input irq_ack_strobe, lock_n, hold_grant, addr, addr_strobe,
                 cycle_status, mem_io, xfer_direction, status_zero_out);
endinterface : cric_if

// >>> verilog/cric_edge_sync.sv
// Two-flop synchroniser with a rising-edge pulse decoded from the settled level and its previous value
`timescale 1ns/100ps
module cric_edge_sync (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic nrst_i,
    // Signal
    input  wire logic sig_i,
    output logic      level_o,
    output logic      rise_o
);
    logic meta_q; // First stage, read only by sync_q
    logic sync_q; // Settled level
    logic last_q; // Previous settled level

    // Synchroniser chain
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= sig_i;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign level_o = sync_q;
    assign rise_o  = sync_q & ~last_q;
endmodule : cric_edge_sync

// >>> verilog/cric_sys_ctrl.sv
// System end: reset, NMI, maskable, type byte and hold sources
`timescale 1ns/100ps
`include "cric_map.svh"
module cric_sys_ctrl #(
    parameter int PWRUP_CYC = `CRIC_PWRUP_CYC
) (
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       nrst_i,
    // Link
    cric_if.sys             link,
    // User side
    input  wire logic       reset_req_i,  // Pulse: request a reset
    input  wire logic       nmi_req_i,    // Pulse: raise NMI
    input  wire logic       irq_req_i,    // Pulse: raise maskable request
    input  wire logic [7:0] irq_type_i,   // Type to return
    input  wire logic       hold_i,       // Level: want the bus
    input  wire logic       minimum_i,    // Strap
    output logic            granted_o,
    output logic            ready_o       // Power-up wait and reset hold done
);
    logic [15:0] pwr_q;    // Power-up counter
    logic [2:0]  rst_q;    // Reset hold counter
    logic        rst_on_q;
    logic [1:0]  nmi_q;    // NMI high counter
    logic        irq_q;
    logic        ack_prev_q;
    logic [7:0]  type_q;

    // Reset from power-up and on request
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            {pwr_q, rst_q} <= 19'h00000;
            rst_on_q <= 1'b1;
        end else begin
            if (pwr_q != 16'(PWRUP_CYC)) pwr_q <= pwr_q + 16'h0001;
            if (reset_req_i) begin
                rst_on_q <= 1'b1;
                rst_q    <= 3'h0;
            end else if (rst_q != 3'(`CRIC_RST_HOLD_CYC)) rst_q <= rst_q + 3'h1;
            else if (pwr_q == 16'(PWRUP_CYC)) rst_on_q <= 1'b0;
        end
    end

    // NMI high three clocks; maskable until first strobe falls
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) {nmi_q, irq_q, ack_prev_q, type_q} <= 12'h000;
        else begin
            if (nmi_req_i && nmi_q == 2'h0) nmi_q <= 2'(`CRIC_NMI_MIN_HIGH_CYC);
            else if (nmi_q != 2'h0) nmi_q <= nmi_q - 2'h1;
            ack_prev_q <= link.irq_ack_strobe;
            if (irq_req_i) begin
                irq_q  <= 1'b1;
                type_q <= irq_type_i;
            end else if (ack_prev_q && !link.irq_ack_strobe) irq_q <= 1'b0;
        end
    end

    assign link.reset_in     = rst_on_q;
    assign link.nmi_in       = nmi_q != 2'h0;
    assign link.mask_irq_in  = irq_q;
    assign link.type_byte    = type_q;
    assign link.hold_req     = hold_i;
    assign link.config_strap = minimum_i;
    assign granted_o         = link.hold_grant;
    assign ready_o           = !rst_on_q;
endmodule : cric_sys_ctrl

// >>> tb/cric_assertions.sv
// Checker on the link between the processor end and the system end
`timescale 1ns/100ps
`include "cric_map.svh"
module cric_assertions #(
    parameter int PWRUP_CYC = 20 // Power-up wait of the system end
) (
    // Clock and reset
    input wire logic        ref_clk_i,
    input wire logic        nrst_i,
    // Link signals
    input wire logic        reset_in,
    input wire logic        nmi_in,
    input wire logic        irq_ack_strobe,
    input wire logic        lock_n,
    input wire logic        hold_grant,
    input wire logic [19:0] addr,
    input wire logic [2:0]  cycle_status,
    input wire logic        config_strap
);
    logic [3:0]  hi_cnt_q; // Cycles reset_in stood high, saturating
    logic [15:0] since_q;  // Cycles since nrst_i release, saturating
    logic        first_q;  // First release of reset_in still ahead
    logic        open_q;   // Next strobe rise opens an acknowledge pair
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    // Reset width; a short pulse would leave the core half initialised
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) hi_cnt_q <= 4'h0;
        else if (!reset_in) hi_cnt_q <= 4'h0;
        else if (hi_cnt_q != 4'hF) hi_cnt_q <= hi_cnt_q + 4'h1;
    end
    // Power-up span, saturating
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) since_q <= 16'h0;
        else if (since_q != 16'hFFFF) since_q <= since_q + 16'h1;
    end
    // First release marker
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) first_q <= 1'b1;
        else if (!reset_in) first_q <= 1'b0;
    end
    // Pair parity; a reset aborts any pair in flight
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) open_q <= 1'b1;
        else if (reset_in) open_q <= 1'b1;
        else if ($rose(irq_ack_strobe)) open_q <= !open_q;
    end
    sequence s_strobe;
        irq_ack_strobe [*2] ##1 !irq_ack_strobe;
    endsequence
    sequence s_first;
        $rose(irq_ack_strobe) && open_q;
    endsequence
    property p_io_upper;
        (cycle_status == `CRIC_ST_IORD || cycle_status == `CRIC_ST_IOWR) |-> addr[19:16] == 4'h0;
    endproperty
    property p_rst_quiet;
        reset_in [*4] |-> cycle_status == `CRIC_ST_PASSIVE && lock_n && !irq_ack_strobe;
    endproperty
    property p_rst_len;
        $fell(reset_in) |-> hi_cnt_q > 4'h4;
    endproperty
    property p_pwrup;
        $fell(reset_in) && first_q |-> since_q >= PWRUP_CYC;
    endproperty
    property p_strobe_len;
        $rose(irq_ack_strobe) |-> s_strobe;
    endproperty
    property p_ack_pair;
        s_first |-> ##[3:5] $rose(irq_ack_strobe);
    endproperty
    property p_lock_ack;
        s_first and !config_strap |-> ##[0:2] !lock_n;
    endproperty
    property p_no_grant_lock;
        !lock_n || irq_ack_strobe |-> !hold_grant;
    endproperty
    property p_nmi_len;
        $rose(nmi_in) |=> nmi_in [*2];
    endproperty
    a_io_upper: assert property (p_io_upper)
        else $error("I/O cycle with upper address bits set");
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("activity while reset held");
    a_rst_len: assert property (p_rst_len)
        else $error("reset pulse too short");
    a_pwrup: assert property (p_pwrup)
        else $error("reset released before power-up wait");
    a_strobe_len: assert property (p_strobe_len)
        else $error("acknowledge strobe of wrong length");
    a_ack_pair: assert property (p_ack_pair)
        else $error("second acknowledge missing");
    a_lock_ack: assert property (p_lock_ack)
        else $error("no lock during acknowledge pair");
    a_no_grant_lock: assert property (p_no_grant_lock)
        else $error("hold granted while locked");
    a_nmi_len: assert property (p_nmi_len)
        else $error("NMI high too briefly");
endmodule : cric_assertions

// >>> tb/cric_tb_top.sv
// Testbench joining the processor end and the system end over the link
`timescale 1ns/100ps
`include "cric_map.svh"
module cric_tb_top;
    logic        ref_clk_i = 1'b0; // 40 MHz clock
    logic        nrst_i    = 1'b0; // Active-low reset
    logic        instr_end = 1'b0, halt_exec = 1'b0, lock_pfx = 1'b0, locked_end = 1'b0;
    logic        io_req = 1'b0, io_wr = 1'b0, io_dir = 1'b0, flags_ld = 1'b0;
    logic        if_set = 1'b0, if_val = 1'b0, rst_req = 1'b0, nmi_req = 1'b0;
    logic        irq_req = 1'b0, hold = 1'b0, minimum = 1'b1;
    logic [15:0] io_port   = 16'h0;
    logic [7:0]  irq_type  = 8'h00;
    logic        fetch, vector, push_fl, int_en, halted, busy, granted, ready;
    logic [19:0] fetch_addr;
    logic [9:0]  vptr;
    logic [19:0] exp_q[$];  // Expected results, oldest first
    int          miscompares = 0, checks = 0, pf_n = 0, srv_n = 0, r;
    int          seed = 32'hbae668df;
    logic [7:0]  typ;
    // Clock
    always #12.5 ref_clk_i = ~ref_clk_i;
    cric_if link ();
    cric_cpu_ctrl cric_cpu_ctrl_i (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .link(link),
        .instr_end_i(instr_end), .halt_exec_i(halt_exec), .lock_prefix_i(lock_pfx),
        .locked_end_i(locked_end), .io_req_i(io_req), .io_write_i(io_wr), .io_direct_i(io_dir),
        .io_port_i(io_port), .flags_load_i(flags_ld), .if_set_i(if_set), .if_value_i(if_val),
        .fetch_o(fetch), .fetch_addr_o(fetch_addr), .vector_o(vector), .vector_ptr_o(vptr),
        .push_flags_o(push_fl), .int_en_o(int_en), .halted_o(halted), .busy_o(busy));
    cric_sys_ctrl #(.PWRUP_CYC(20)) cric_sys_ctrl_i (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
        .link(link), .reset_req_i(rst_req), .nmi_req_i(nmi_req), .irq_req_i(irq_req),
        .irq_type_i(irq_type), .hold_i(hold), .minimum_i(minimum), .granted_o(granted),
        .ready_o(ready));
    cric_assertions #(.PWRUP_CYC(20)) cric_assertions_i (.ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i), .reset_in(link.reset_in), .nmi_in(link.nmi_in),
        .irq_ack_strobe(link.irq_ack_strobe), .lock_n(link.lock_n),
        .hold_grant(link.hold_grant), .addr(link.addr), .cycle_status(link.cycle_status),
        .config_strap(link.config_strap));
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : cyc
    task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Waits out power-up and init
    task automatic settle;
        cyc(8);
        for (int n = 0; n < 400 && (busy !== 1'b0 || ready !== 1'b1); n++) cyc(1);
        cyc(4);
    endtask : settle
    // Request pulses, then synchroniser time
    task automatic raise(input bit irq, input bit nmi);
        irq_req <= irq;
        nmi_req <= nmi;
        cyc(1);
        irq_req <= 1'b0;
        nmi_req <= 1'b0;
        cyc(6);
    endtask : raise
    // Sets enable by instruction or flags restore
    task automatic en(input bit via_load);
        if_set   <= !via_load;
        flags_ld <= via_load;
        if_val   <= 1'b1;
        cyc(1);
        if_set   <= 1'b0;
        flags_ld <= 1'b0;
        cyc(3);
    endtask : en
    // Boundary; notes the expected pointer
    task automatic svc(input bit want, input logic [9:0] v);
        if (want) exp_q.push_back({10'h0, v});
        srv_n += want;
        instr_end <= 1'b1;
        cyc(1);
        instr_end <= 1'b0;
        cyc(16);
    endtask : svc
    task automatic end_sim;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim
    // Each fetch or vector takes the oldest note
    always @(posedge ref_clk_i) begin
        if (push_fl === 1'b1) pf_n++;
        if (vector === 1'b1 || fetch === 1'b1) begin
            if (exp_q.size() == 0) chk("unexpected", 20'h0, 20'h1);
            else chk("result", vector ? {10'h0, vptr} : fetch_addr, exp_q.pop_front());
        end
    end
    // Watchdog
    initial begin
        cyc(6000);
        miscompares++;
        end_sim();
    end
    initial begin
        exp_q.push_back(`CRIC_RESTART_ADDR);
        cyc(3);
        nrst_i <= 1'b1;
        settle();
        for (int m = 1; m >= 0; m--) begin
            minimum  <= m[0];
            typ      = 8'($random(seed));
            irq_type <= typ;
            raise(1'b1, 1'b0);
            svc(1'b0, 10'h0);
            en(1'b0);
            chk("int_en", 20'(int_en), 20'h1);
            svc(1'b1, {typ, 2'b00});
            chk("int_en", 20'(int_en), 20'h0);
            en(1'b0);
            raise(1'b1, 1'b1);
            svc(1'b1, 10'h008);
            en(1'b1);
            svc(1'b1, {typ, 2'b00});
        end
        en(1'b0);
        halt_exec <= 1'b1;
        instr_end <= 1'b1;
        cyc(1);
        halt_exec <= 1'b0;
        instr_end <= 1'b0;
        cyc(4);
        chk("halted", 20'(halted), 20'h1);
        hold <= 1'b1;
        cyc(12);
        chk("granted", 20'(granted), 20'h1);
        hold <= 1'b0;
        cyc(12);
        chk("halted", 20'(halted), 20'h1);
        raise(1'b1, 1'b0);
        svc(1'b1, {typ, 2'b00});
        chk("halted", 20'(halted), 20'h0);
        lock_pfx <= 1'b1;
        hold     <= 1'b1;
        cyc(1);
        lock_pfx <= 1'b0;
        cyc(12);
        chk("granted", 20'(granted), 20'h0);
        locked_end <= 1'b1;
        cyc(1);
        locked_end <= 1'b0;
        cyc(8);
        chk("granted", 20'(granted), 20'h1);
        hold <= 1'b0;
        cyc(8);
        // Random ports; the checker watches the address
        repeat (4) begin
            r = $random(seed);
            io_port <= r[15:0];
            io_dir  <= r[16];
            io_wr   <= r[17];
            io_req  <= 1'b1;
            cyc(1);
            io_req  <= 1'b0;
            cyc(8);
        end
        exp_q.push_back(`CRIC_RESTART_ADDR);
        rst_req <= 1'b1;
        cyc(1);
        rst_req <= 1'b0;
        settle();
        chk("pushes", 20'(pf_n), 20'(srv_n));
        chk("pending", 20'(exp_q.size()), 20'h0);
        end_sim();
    end
endmodule : cric_tb_top
